// ### rtl/bmc_top.sv
// Supply brown-out monitor control and status with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "bmc_defines.svh"

// What this block does
// R1 - Config bit 7 sets default detection enable
// R2 - Config bits 6:5 pick threshold level
// R3 - Config bit 4 sets default reset choice
// R4 - Control bit 7 switches detection on
// R5 - Control bit 4 allows reset on drop
// R6 - Every reset reloads enables from config
// R7 - Event flag set on either crossing
// R8 - Interrupt needs both enables plus flag
// R9 - Only software or a reset clears the event flag
// R10 - Sampled mode only counts while enabled
// R11 - Sampled mode runs oscillator, no hysteresis
// R12 - Status read-only, zero when disabled
// R13 - Status one means supply below threshold
// R14 - Software clears stale flag at start
// R15 - Power-on reset sets cold start flag
// R16 - Cold flag survives warm resets
// R17 - No re-set while supply stays low
// R18 - Drop reset sets sticky reset flag
// R19 - Flag after reset follows supply state
// R20 - Comparator synchronised before edge detect
module bmc_top
	import bmc_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int SAMPLE_TICKS = `BMC_SAMPLE_TICKS
) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic POR_I,
	input wire logic CE_I,
	input wire logic [7:0] CFG_BYTE_I,
	input wire logic SUPPLY_LOW_I,
	input wire logic SLOW_OSC_I,
	input wire logic SUPPLY_EVENT_IRQ_EN_I,
	input wire logic GLOBAL_IRQ_EN_I,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output logic [1:0] THRESHOLD_SEL_O,
	output logic DETECT_EN_O,
	output logic HYSTERESIS_EN_O,
	output logic SLOW_OSC_EN_O,
	output logic SUPPLY_IRQ_O,
	output logic DROPOUT_RESET_O
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		hits = (addr == ADDR_W'({idx, 2'b00}));
	endfunction

	// ************************************************************
	// Declarations
	// ************************************************************
	wire any_reset = RESET_I | POR_I;

	logic sync1_reg;
	logic sync2_reg;
	logic [1:0] prime_reg;
	logic level_reg;
	logic level_next;
	logic detector_enable_reg;
	logic detector_enable_next;
	logic dropout_reset_enable_reg;
	logic dropout_reset_enable_next;
	logic sampled_detect_reg;
	logic sampled_detect_next;
	logic event_flag_reg;
	logic event_flag_next;
	logic cold_flag_reg;
	logic cold_flag_next;
	logic drop_flag_reg;
	logic drop_flag_next;
	logic sample_strobe;

	logic aw_full_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic w_full_reg;
	logic [7:0] w_data_reg;
	logic w_lane_reg;
	bmc_byte_t rd_byte;

	// ************************************************************
	// Register decode
	// ************************************************************
	wire wr_fire = aw_full_reg & w_full_reg & ~S_AXI_BVALID_O;
	wire wr_lane = wr_fire & w_lane_reg;
	wire wr_cfg = hits(aw_addr_reg, `BMC_IDX_CONFIG);
	wire wr_pwr = hits(aw_addr_reg, `BMC_IDX_POWER_CONTROL);
	wire wr_rsr = hits(aw_addr_reg, `BMC_IDX_RESET_STATUS);
	wire wr_mon = hits(aw_addr_reg, `BMC_IDX_MONITOR_CONTROL);
	wire wr_hit = wr_cfg | wr_pwr | wr_rsr | wr_mon;
	wire mon_we = wr_lane & wr_mon;
	wire pwr_we = wr_lane & wr_pwr;
	wire rsr_we = wr_lane & wr_rsr;

	wire ar_fire = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
	wire rd_cfg = hits(S_AXI_ARADDR_I, `BMC_IDX_CONFIG);
	wire rd_pwr = hits(S_AXI_ARADDR_I, `BMC_IDX_POWER_CONTROL);
	wire rd_rsr = hits(S_AXI_ARADDR_I, `BMC_IDX_RESET_STATUS);
	wire rd_mon = hits(S_AXI_ARADDR_I, `BMC_IDX_MONITOR_CONTROL);
	wire rd_hit = rd_cfg | rd_pwr | rd_rsr | rd_mon;

	// ************************************************************
	// Supply sensing
	// ************************************************************
	wire lp_active = detector_enable_reg & sampled_detect_reg; // R10
	wire primed = prime_reg[1];
	// Sampled mode only looks at the comparator on the interval strobe
	wire sample_go = primed & (~lp_active | sample_strobe); // R11
	wire crossing = sample_go & detector_enable_reg & (sync2_reg != level_reg); // R7 R17
	wire falling = crossing & sync2_reg;
	wire drop_reset = falling & dropout_reset_enable_reg; // R5
	// Gated so that status cannot show a stale level while disabled
	wire supply_low_status = detector_enable_reg & level_reg; // R12 R13

	assign level_next = sample_go ? sync2_reg : level_reg;

	bmc_sample_timer #(
		.TICKS(SAMPLE_TICKS),
		.CNT_W(8)
	) bmc_sample_timer_i (
		.clk_i(SYS_CLK_I),
		.rst_i(any_reset),
		.ce_i(CE_I),
		.run_i(lp_active),
		.slow_osc_i(SLOW_OSC_I),
		.strobe_o(sample_strobe)
	);

	// ************************************************************
	// Control and flag next values
	// ************************************************************
	assign detector_enable_next = mon_we ? w_data_reg[`BMC_MON_EN_BIT] :
		detector_enable_reg; // R4
	assign dropout_reset_enable_next = mon_we ? w_data_reg[`BMC_MON_RST_BIT] :
		dropout_reset_enable_reg; // R5
	assign sampled_detect_next = mon_we ? w_data_reg[`BMC_MON_LP_BIT] :
		sampled_detect_reg;
	// Hardware set wins over a same-cycle software clear
	assign event_flag_next = crossing ? 1'b1 :
		(mon_we ? w_data_reg[`BMC_MON_EVT_BIT] : event_flag_reg); // R9
	assign cold_flag_next = pwr_we ? w_data_reg[`BMC_PWR_COLD_BIT] : cold_flag_reg;
	assign drop_flag_next = drop_reset ? 1'b1 :
		(rsr_we ? w_data_reg[`BMC_RSR_DROP_BIT] : drop_flag_reg); // R18

	// ************************************************************
	// Comparator synchroniser
	// ************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (any_reset) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prime_reg <= 2'h0;
		end else if (CE_I) begin
			sync1_reg <= SUPPLY_LOW_I; // R20
			sync2_reg <= sync1_reg; // R20
			prime_reg <= {prime_reg[0], 1'b1};
		end
	end

	// ************************************************************
	// Runtime control, reloaded on every reset
	// ************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (any_reset) begin
			detector_enable_reg <= CFG_BYTE_I[`BMC_CFG_EN_BIT]; // R1 R6
			dropout_reset_enable_reg <= CFG_BYTE_I[`BMC_CFG_RST_BIT]; // R3 R6
			sampled_detect_reg <= 1'b0;
			// Level starts low, so a supply found high after reset flags an event
			level_reg <= 1'b1; // R19
			event_flag_reg <= 1'b0; // R19
		end else if (CE_I) begin
			detector_enable_reg <= detector_enable_next;
			dropout_reset_enable_reg <= dropout_reset_enable_next;
			sampled_detect_reg <= sampled_detect_next;
			level_reg <= level_next;
			event_flag_reg <= event_flag_next;
		end
	end

	// ************************************************************
	// Reset-source flags, untouched by warm resets
	// ************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (POR_I) begin
			cold_flag_reg <= 1'b1; // R15
			drop_flag_reg <= 1'b0; // R18
		end else if (CE_I) begin
			cold_flag_reg <= cold_flag_next; // R16
			drop_flag_reg <= drop_flag_next; // R18
		end
	end

	// ************************************************************
	// Outputs toward analog and CPU
	// ************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (any_reset) begin
			THRESHOLD_SEL_O <= 2'h3;
			DETECT_EN_O <= 1'b0;
			HYSTERESIS_EN_O <= 1'b0;
			SLOW_OSC_EN_O <= 1'b0;
			SUPPLY_IRQ_O <= 1'b0;
			DROPOUT_RESET_O <= 1'b0;
		end else if (CE_I) begin
			THRESHOLD_SEL_O <= {CFG_BYTE_I[`BMC_CFG_THR_HI_BIT],
				CFG_BYTE_I[`BMC_CFG_THR_LO_BIT]}; // R2
			DETECT_EN_O <= detector_enable_reg; // R4
			HYSTERESIS_EN_O <= detector_enable_reg & ~lp_active; // R11
			SLOW_OSC_EN_O <= lp_active; // R11
			SUPPLY_IRQ_O <= event_flag_reg & SUPPLY_EVENT_IRQ_EN_I & GLOBAL_IRQ_EN_I; // R8
			// One-cycle request; the CPU reset logic stretches it
			DROPOUT_RESET_O <= drop_reset; // R5
		end
	end

	// ************************************************************
	// AXI4-Lite write channels
	// ************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (any_reset) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			S_AXI_AWREADY_O <= 1'b1;
		end else if (CE_I) begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR_I;
				S_AXI_AWREADY_O <= 1'b0;
			end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				aw_full_reg <= 1'b0;
				S_AXI_AWREADY_O <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (any_reset) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
			S_AXI_WREADY_O <= 1'b1;
		end else if (CE_I) begin
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_full_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA_I[7:0];
				w_lane_reg <= S_AXI_WSTRB_I[0];
				S_AXI_WREADY_O <= 1'b0;
			end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				w_full_reg <= 1'b0;
				S_AXI_WREADY_O <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (any_reset) begin
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= `BMC_RESP_OKAY;
		end else if (CE_I) begin
			if (wr_fire) begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= wr_hit ? `BMC_RESP_OKAY : `BMC_RESP_SLVERR;
			end else if (S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	// ************************************************************
	// AXI4-Lite read channels
	// ************************************************************
	// Config byte is a read-only mirror; writes to it are accepted and dropped
	assign rd_byte = rd_cfg ? CFG_BYTE_I :
		rd_pwr ? bmc_byte_t'({3'h0, cold_flag_reg, 4'h0}) :
		rd_rsr ? bmc_byte_t'({5'h00, drop_flag_reg, 2'h0}) :
		rd_mon ? bmc_byte_t'({detector_enable_reg, 2'h0, dropout_reset_enable_reg,
			event_flag_reg, sampled_detect_reg, 1'b0, supply_low_status}) :
		8'h00;

	always_ff @(posedge SYS_CLK_I) begin
		if (any_reset) begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h0000_0000;
			S_AXI_RRESP_O <= `BMC_RESP_OKAY;
		end else if (CE_I) begin
			if (ar_fire) begin
				S_AXI_ARREADY_O <= 1'b0;
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O <= {24'h00_0000, rd_byte};
				S_AXI_RRESP_O <= rd_hit ? `BMC_RESP_OKAY : `BMC_RESP_SLVERR;
			end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
				S_AXI_ARREADY_O <= 1'b1;
				S_AXI_RVALID_O <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ### pkg/bmc_defines.svh
// Offsets, field positions, reset values and timing counts of the supply monitor
`ifndef BMC_DEFINES_SVH
`define BMC_DEFINES_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define BMC_IDX_CONFIG 8'h00
`define BMC_IDX_POWER_CONTROL 8'h87
`define BMC_IDX_RESET_STATUS 8'h96
`define BMC_IDX_MONITOR_CONTROL 8'hac

// ************************************************************
// Field positions
// ************************************************************
`define BMC_CFG_EN_BIT 7
`define BMC_CFG_THR_HI_BIT 6
`define BMC_CFG_THR_LO_BIT 5
`define BMC_CFG_RST_BIT 4
`define BMC_MON_EN_BIT 7
`define BMC_MON_RST_BIT 4
`define BMC_MON_EVT_BIT 3
`define BMC_MON_LP_BIT 2
`define BMC_MON_STAT_BIT 0
`define BMC_PWR_COLD_BIT 4
`define BMC_RSR_DROP_BIT 2

// ************************************************************
// Reset values and bus answers
// ************************************************************
`define BMC_CFG_UNPROG 8'hff
`define BMC_RESP_OKAY 2'h0
`define BMC_RESP_SLVERR 2'h2

// ************************************************************
// Timing
// ************************************************************
`define BMC_SLOW_OSC_HZ 10000
`define BMC_SAMPLE_INTERVAL_US 12800
`define BMC_SAMPLE_TICKS (`BMC_SAMPLE_INTERVAL_US * `BMC_SLOW_OSC_HZ / 1000000)

`endif

// ### pkg/bmc_pkg.sv
// Types shared by the supply monitor files
`default_nettype none
package bmc_pkg;

	typedef logic [7:0] bmc_byte_t;
	typedef logic [1:0] bmc_resp_t;

endpackage
`default_nettype wire

// ### rtl/bmc_sample_timer.sv
// Interval timer for sampled detection, counted on slow oscillator edges
`timescale 1ns/100ps
`default_nettype none
`include "bmc_defines.svh"

module bmc_sample_timer
	import bmc_pkg::*;
#(
	parameter int TICKS = `BMC_SAMPLE_TICKS,
	parameter int CNT_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic run_i,
	input wire logic slow_osc_i,
	output logic strobe_o
);

	logic osc_d_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic strobe_next;
	wire osc_rise = slow_osc_i & ~osc_d_reg;
	wire at_end = (count_reg == CNT_W'(TICKS - 1));

	// One strobe per TICKS slow oscillator periods while sampling runs
	assign strobe_next = run_i & osc_rise & at_end; // R11
	assign count_next = (!run_i || strobe_next) ? '0 :
		(osc_rise ? count_reg + CNT_W'(1) : count_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_d_reg <= 1'b0;
			count_reg <= '0;
			strobe_o <= 1'b0;
		end else if (ce_i) begin
			osc_d_reg <= slow_osc_i;
			count_reg <= count_next;
			strobe_o <= strobe_next;
		end
	end

endmodule
`default_nettype wire

// ### sim/bmc_supply_model.sv
// Comparator and slow oscillator model facing the supply monitor
`timescale 1ns/100ps
`default_nettype none
module bmc_supply_model #(
	parameter int HALF = 10
) (
	input wire logic clk_i,
	input wire logic level_i,
	input wire logic osc_en_i,
	output logic supply_low_o,
	output var logic slow_osc_o
);
	int cnt = 0;
	assign supply_low_o = level_i;
	// Stands still outside sampled mode, so no stray ticks
	always @(posedge clk_i) begin
		if (!osc_en_i) begin
			cnt <= 0;
			slow_osc_o <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			slow_osc_o <= ~slow_osc_o;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ### sim/bmc_monitor.sv
// Concurrent checks on the supply monitor ports
`timescale 1ns/100ps
`default_nettype none
module bmc_monitor (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic POR_I,
	input wire logic CE_I,
	input wire logic [7:0] CFG_BYTE_I,
	input wire logic SUPPLY_EVENT_IRQ_EN_I,
	input wire logic GLOBAL_IRQ_EN_I,
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic [1:0] THRESHOLD_SEL_O,
	input wire logic DETECT_EN_O,
	input wire logic HYSTERESIS_EN_O,
	input wire logic SLOW_OSC_EN_O,
	input wire logic SUPPLY_IRQ_O,
	input wire logic DROPOUT_RESET_O
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I || POR_I);
	sequence s_wtake;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence s_rtake;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	property p_wr;
		s_wtake |=> !S_AXI_AWREADY_O ##[0:1] S_AXI_BVALID_O;
	endproperty
	a_wr: assert property (p_wr) else $error("write answer late");
	property p_rd;
		s_rtake |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_bhold;
		S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold;
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O;
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_thr;
		!$past(RESET_I || POR_I) |-> THRESHOLD_SEL_O == $past(CFG_BYTE_I[6:5]);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold select wrong");
	property p_irq;
		// A frozen block keeps its request, so only running cycles count
		CE_I && !(SUPPLY_EVENT_IRQ_EN_I && GLOBAL_IRQ_EN_I) |=> !SUPPLY_IRQ_O;
	endproperty
	a_irq: assert property (p_irq) else $error("request while masked");
	property p_drop;
		DROPOUT_RESET_O |-> DETECT_EN_O ##1 !DROPOUT_RESET_O;
	endproperty
	a_drop: assert property (p_drop) else $error("bad reset pulse");
	property p_hyst;
		HYSTERESIS_EN_O == (DETECT_EN_O && !SLOW_OSC_EN_O);
	endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis wrong");
	property p_slow;
		SLOW_OSC_EN_O |-> DETECT_EN_O;
	endproperty
	a_slow: assert property (p_slow) else $error("oscillator on while off");
endmodule
`default_nettype wire

// ### sim/bmc_top_tb.sv
// Self-checking bench for the supply monitor control block
`timescale 1ns/100ps
`default_nettype none
bind bmc_top bmc_monitor bmc_monitor_i (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .POR_I(POR_I),
	.CE_I(CE_I), .CFG_BYTE_I(CFG_BYTE_I), .SUPPLY_EVENT_IRQ_EN_I(SUPPLY_EVENT_IRQ_EN_I),
	.GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
	.S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
	.S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.S_AXI_RREADY_I(S_AXI_RREADY_I), .THRESHOLD_SEL_O(THRESHOLD_SEL_O),
	.DETECT_EN_O(DETECT_EN_O), .HYSTERESIS_EN_O(HYSTERESIS_EN_O),
	.SLOW_OSC_EN_O(SLOW_OSC_EN_O), .SUPPLY_IRQ_O(SUPPLY_IRQ_O), .DROPOUT_RESET_O(DROPOUT_RESET_O));
module bmc_top_tb;
	logic clk = 1'b0, rst = 1'b0, por = 1'b1, lvl = 1'b0, ie = 1'b1, ge = 1'b1, ce = 1'b1;
	logic [3:0] wstrb = 4'h1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] cfg = 8'hff;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	wire logic awready, wready, bvalid, arready, rvalid, det, hyst, osc_en, irq, drop, sup, osc;
	wire logic [1:0] bresp, rresp, thr;
	wire logic [31:0] rdata;
	int errors = 0, n_checks = 0;
	always #20 clk = ~clk;
	bmc_top #(.SAMPLE_TICKS(4)) bmc_top_i (.SYS_CLK_I(clk), .RESET_I(rst), .POR_I(por),
		.CE_I(ce), .CFG_BYTE_I(cfg), .SUPPLY_LOW_I(sup), .SLOW_OSC_I(osc),
		.SUPPLY_EVENT_IRQ_EN_I(ie), .GLOBAL_IRQ_EN_I(ge), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .THRESHOLD_SEL_O(thr), .DETECT_EN_O(det),
		.HYSTERESIS_EN_O(hyst), .SLOW_OSC_EN_O(osc_en), .SUPPLY_IRQ_O(irq),
		.DROPOUT_RESET_O(drop));
	bmc_supply_model bmc_supply_model_i (.clk_i(clk), .level_i(lvl), .osc_en_i(osc_en),
		.supply_low_o(sup), .slow_osc_o(osc));
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic conclude();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			errors++;
		end
	endtask
	task automatic tmo(input int i);
		if (i >= 50) begin
			$display("unexpected timeout");
			errors++;
			conclude();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		int i;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		tmo(i);
		chk("bresp", er, bresp);
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		tmo(i);
		chk("rdata", {24'h0, e}, rdata);
		chk("rresp", er, rresp);
		rready <= 1'b0;
		@(posedge clk);
	endtask
	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		int i;
		repeat (4) @(posedge clk);
		por <= 1'b0;
		// Outputs show the reloaded enables from the first free edge on
		repeat (2) @(posedge clk);
		chk("thr", 2'b11, thr);
		chk("det", 1'b1, det);
		rd(12'h21c, 8'h10, 2'h0);
		rd(12'h258, 8'h00, 2'h0);
		rd(12'h000, 8'hff, 2'h0);
		rd(12'h2b0, 8'h98, 2'h0);
		wr(12'h2b0, 8'h90, 2'h0);
		rd(12'h2b0, 8'h90, 2'h0);
		wr(12'h2b0, 8'h80, 2'h0);
		lvl <= 1'b1;
		repeat (8) @(posedge clk);
		chk("irq", 1'b1, irq);
		ce <= 1'b0;
		ge <= 1'b0;
		repeat (2) @(posedge clk);
		chk("irq", 1'b1, irq);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk("irq", 1'b0, irq);
		rd(12'h2b0, 8'h89, 2'h0);
		wr(12'h2b0, 8'h80, 2'h0);
		repeat (8) @(posedge clk);
		rd(12'h2b0, 8'h81, 2'h0);
		lvl <= 1'b0;
		repeat (8) @(posedge clk);
		rd(12'h2b0, 8'h88, 2'h0);
		wr(12'h2b0, 8'h01, 2'h0);
		lvl <= 1'b1;
		repeat (8) @(posedge clk);
		rd(12'h2b0, 8'h00, 2'h0);
		lvl <= 1'b0;
		repeat (8) @(posedge clk);
		wr(12'h2b0, 8'h90, 2'h0);
		lvl <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (drop) break;
		end
		chk("drop", 1'b1, drop);
		rd(12'h258, 8'h04, 2'h0);
		wr(12'h21c, 8'h00, 2'h0);
		lvl <= 1'b0;
		cfg <= 8'h4f;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk("thr", 2'b10, thr);
		chk("det", 1'b0, det);
		rd(12'h21c, 8'h00, 2'h0);
		rd(12'h258, 8'h04, 2'h0);
		rd(12'h2b0, 8'h00, 2'h0);
		rd(12'h004, 8'h00, 2'h2);
		wr(12'h004, 8'h55, 2'h2);
		wr(12'h000, 8'h00, 2'h0);
		rd(12'h000, 8'h4f, 2'h0);
		wstrb <= 4'h0;
		wr(12'h21c, 8'h10, 2'h0);
		wstrb <= 4'h1;
		rd(12'h21c, 8'h00, 2'h0);
		wr(12'h2b0, 8'h84, 2'h0);
		chk("osc", 1'b1, osc_en);
		chk("hyst", 1'b0, hyst);
		lvl <= 1'b1;
		repeat (200) @(posedge clk);
		rd(12'h2b0, 8'h8d, 2'h0);
		wr(12'h2b0, 8'h04, 2'h0);
		chk("osc", 1'b0, osc_en);
		conclude();
	end
endmodule
`default_nettype wire
